/* File: dpcc_consts.vh */
`ifndef DPCC_CONSTS_VH
`define DPCC_CONSTS_VH

// ************************************************************
// Object dictionary indices and subindices
// ************************************************************
`define DPCC_IDX_VAL32_B    16'h4014
`define DPCC_IDX_HALF_B     16'h4015
`define DPCC_IDX_OCTET_B    16'h4016
`define DPCC_IDX_SELECT     16'h402F
`define DPCC_IDX_CTRL       16'h60B8
`define DPCC_IDX_STAT       16'h60B9
`define DPCC_IDX_SRC        16'h60D0
`define DPCC_IDX_RCNT_A     16'h60D5
`define DPCC_IDX_FCNT_A     16'h60D6
`define DPCC_IDX_RCNT_B     16'h60D7
`define DPCC_IDX_FCNT_B     16'h60D8
`define DPCC_SUB_COUNT      8'h00
`define DPCC_SUB_V0         8'h01
`define DPCC_SUB_V1         8'h02
`define DPCC_SUB_V2         8'h03
`define DPCC_GROUP_COUNT    32'h00000003
`define DPCC_SRC_COUNT      32'h00000002

// ************************************************************
// Control and status word bit positions
// ************************************************************
`define DPCC_B_OFS          8
`define DPCC_BIT_EN         0
`define DPCC_BIT_REP        1
`define DPCC_BIT_TRIG       2
`define DPCC_BIT_RISE       4
`define DPCC_BIT_FALL       5
`define DPCC_BIT_USER0      6
`define DPCC_BIT_USER1      7
`define DPCC_ST_RISE        1
`define DPCC_ST_FALL        2
`define DPCC_CTRL_MASK      16'hF7F7

// ************************************************************
// Reset values and codes
// ************************************************************
`define DPCC_CTRL_RST       16'h0000
`define DPCC_SEL_CUSTOM     16'h0000
`define DPCC_SEL_CIA402     16'h0001
`define DPCC_SRC_A_RST      16'h0001
`define DPCC_SRC_B_RST      16'h0000
`define DPCC_SRC_PROBE1     16'h0001
`define DPCC_SRC_PROBE2     16'h0002
`define DPCC_SRC_FBIDX      16'h0005
`define DPCC_SRC_MASTER     16'hFFFF

`endif

/* File: dpcc_sync.v */
`timescale 1ns/10ps
// ************************************************************
// Two-stage synchroniser for the four trigger pins
// ************************************************************
module dpcc_sync (
  input  wire       sys_clk,  // System clock
  input  wire       reset_n,  // Synchronous reset, active low
  input  wire [3:0] pin_in,   // Asynchronous pin levels
  output reg  [3:0] sync_q    // Synchronised levels
);
  reg [3:0] meta_q;

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      meta_q <= 4'h0;
      sync_q <= 4'h0;
    end else begin
      meta_q <= pin_in;
      sync_q <= meta_q;
    end
  end
endmodule // dpcc_sync

/* File: dpcc_unit.v */
`timescale 1ns/10ps
// ************************************************************
// One capture unit: edge detect, capture, flags, counters
// ************************************************************
module dpcc_unit (
  input  wire        sys_clk,     // System clock
  input  wire        reset_n,     // Synchronous reset, active low
  input  wire        enable,      // Unit enable
  input  wire        repeat_mode, // 1 = repetitive, 0 = single
  input  wire        rise_en,     // Capture on rising edge
  input  wire        fall_en,     // Capture on falling edge
  input  wire        trig,        // Synchronised trigger level
  input  wire [31:0] q0,          // Quantity 0 to capture
  input  wire [31:0] q1,          // Quantity 1 to capture
  input  wire [31:0] q2,          // Quantity 2 to capture
  output reg  [31:0] cap0_q,      // Captured quantity 0
  output reg  [31:0] cap1_q,      // Captured quantity 1
  output reg  [31:0] cap2_q,      // Captured quantity 2
  output reg         rise_seen_q, // Rising capture done
  output reg         fall_seen_q, // Falling capture done
  output reg  [15:0] rise_cnt_q,  // Rising captures count
  output reg  [15:0] fall_cnt_q,  // Falling captures count
  output reg         active_q     // Capture still armed
);
  reg  trig_prev_q;
  wire rise_take;
  wire fall_take;
  wire single_done;

  // Single mode takes one value per edge until re-enabled
  assign rise_take = enable & rise_en & trig & ~trig_prev_q
                   & (repeat_mode | ~rise_seen_q);
  assign fall_take = enable & fall_en & ~trig & trig_prev_q
                   & (repeat_mode | ~fall_seen_q);
  assign single_done = (~rise_en | rise_seen_q) & (~fall_en | fall_seen_q);

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      trig_prev_q <= 1'b0;
      cap0_q      <= 32'h00000000;
      cap1_q      <= 32'h00000000;
      cap2_q      <= 32'h00000000;
      rise_seen_q <= 1'b0;
      fall_seen_q <= 1'b0;
      rise_cnt_q  <= 16'h0000;
      fall_cnt_q  <= 16'h0000;
      active_q    <= 1'b0;
    end else begin
      trig_prev_q <= trig;
      if (rise_take | fall_take) begin
        cap0_q <= q0;
        cap1_q <= q1;
        cap2_q <= q2;
      end
      if (rise_take) begin
        rise_seen_q <= 1'b1;
        rise_cnt_q  <= rise_cnt_q + 16'h0001;
      end else if (!enable) begin
        rise_seen_q <= 1'b0;
      end
      if (fall_take) begin
        fall_seen_q <= 1'b1;
        fall_cnt_q  <= fall_cnt_q + 16'h0001;
      end else if (!enable) begin
        fall_seen_q <= 1'b0;
      end
      active_q <= enable & (repeat_mode | ~single_done);
    end
  end
endmodule // dpcc_unit

/* File: dpcc_top.v */
`timescale 1ns/10ps
// Contract
// - Unit B quantities readable as signed 16-bit copies, three entries.
// - Unit B quantities readable as signed 8-bit copies, three entries.
// - Unit B quantities kept as signed 32-bit read-only values.
// - Selector: 0 custom, 1 CiA-402 management; resets to 0.
// - In custom mode, selector change refused while a unit is active.
// - In CiA-402 mode, refuse change if bit 0 or 8 set in both words.
// - Control bit 0 enables unit A, bit 8 unit B; resets to 0.
// - Bits 1 and 9: single capture when clear, repetitive when set.
// - Bits 2 and 10: digital input when clear, encoder index when set.
// - Bits 4 and 12 enable rising edge capture.
// - Bits 5 and 13 enable falling edge capture.
// - Bits 3 and 11 reserved; 6, 7, 14, 15 stored for the user.
// - Status bits 0 and 8 show units A and B enabled.
// - Status bits 1 and 9 read 0 until a rising capture.
// - Status bits 2 and 10 read 0 until a falling capture.
// - Source codes: 1 probe 1, 2 probe 2, 5 index, -1 master index.
// - Separate read-only 16-bit rising and falling counters per unit.
`include "dpcc_consts.vh"

module dpcc_top (
  input  wire        sys_clk,       // System clock, 100 MHz
  input  wire        reset_n,       // Synchronous reset, active low
  input  wire        probe_in1,     // Probe digital input 1 pin
  input  wire        probe_in2,     // Probe digital input 2 pin
  input  wire        fb_index,      // Feedback encoder index pin
  input  wire        master_index,  // Master encoder index pin
  input  wire [31:0] quantity0,     // Live quantity 0 (position)
  input  wire [31:0] quantity1,     // Live quantity 1
  input  wire [31:0] quantity2,     // Live quantity 2
  input  wire [15:0] obj_index,     // Object index of access
  input  wire [7:0]  obj_sub,       // Object subindex of access
  input  wire        obj_wr,        // Write strobe
  input  wire        obj_rd,        // Read strobe
  input  wire [31:0] obj_wdata,     // Write data
  output reg  [31:0] obj_rdata,     // Read data
  output reg         obj_ack,       // Access accepted pulse
  output reg         obj_err,       // Access refused pulse
  output reg         unit_a_active_flag, // Unit A capture armed
  output reg         unit_b_active_flag  // Unit B capture armed
);

  // ************************************************************
  // Functions
  // ************************************************************
  // Trigger pick: pins are {master, fb index, probe2, probe1}
  function pick_trig;
    input        use_index;
    input [15:0] src;
    input [3:0]  pins;
    begin
      if (use_index) begin
        pick_trig = pins[2];
      end else begin
        case (src)
          `DPCC_SRC_PROBE1: pick_trig = pins[0];
          `DPCC_SRC_PROBE2: pick_trig = pins[1];
          `DPCC_SRC_FBIDX:  pick_trig = pins[2];
          `DPCC_SRC_MASTER: pick_trig = pins[3];
          default:          pick_trig = 1'b0;
        endcase
      end
    end
  endfunction

  function hit;
    input [15:0] idx;
    input [7:0]  sub;
    begin
      hit = (obj_index == idx) && (obj_sub == sub);
    end
  endfunction

  // ************************************************************
  // Registers and wires
  // ************************************************************
  reg  [15:0] ctrl_q;
  reg  [15:0] select_q;
  reg  [15:0] src_a_q;
  reg  [15:0] src_b_q;
  reg  [15:0] stat_q;
  reg  [31:0] rd_d;
  reg         rd_hit_d;
  reg         wr_ok_d;
  wire [3:0]  pins_sync;
  wire        trig_a;
  wire        trig_b;
  wire [31:0] a_cap0;
  wire [31:0] a_cap1;
  wire [31:0] a_cap2;
  wire [31:0] b_cap0;
  wire [31:0] b_cap1;
  wire [31:0] b_cap2;
  wire        a_rise_seen;
  wire        a_fall_seen;
  wire        b_rise_seen;
  wire        b_fall_seen;
  wire [15:0] a_rise_cnt;
  wire [15:0] a_fall_cnt;
  wire [15:0] b_rise_cnt;
  wire [15:0] b_fall_cnt;
  wire        a_active;
  wire        b_active;
  wire        sel_locked;
  wire        sel_w;
  wire        ctrl_w;
  wire        srca_w;
  wire        srcb_w;
  wire [15:0] wr16;

  localparam BE = `DPCC_B_OFS;

  // ************************************************************
  // Pin synchronisation and trigger selection
  // ************************************************************
  dpcc_sync u_sync (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .pin_in  ({master_index, fb_index, probe_in2, probe_in1}),
    .sync_q  (pins_sync)
  );

  assign trig_a = pick_trig(ctrl_q[`DPCC_BIT_TRIG], src_a_q, pins_sync);
  assign trig_b = pick_trig(ctrl_q[`DPCC_BIT_TRIG + `DPCC_B_OFS], src_b_q,
                            pins_sync);

  // ************************************************************
  // Capture units
  // ************************************************************
  dpcc_unit u_unit_a (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .enable      (ctrl_q[`DPCC_BIT_EN]),
    .repeat_mode (ctrl_q[`DPCC_BIT_REP]),
    .rise_en     (ctrl_q[`DPCC_BIT_RISE]),
    .fall_en     (ctrl_q[`DPCC_BIT_FALL]),
    .trig        (trig_a),
    .q0          (quantity0),
    .q1          (quantity1),
    .q2          (quantity2),
    .cap0_q      (a_cap0),
    .cap1_q      (a_cap1),
    .cap2_q      (a_cap2),
    .rise_seen_q (a_rise_seen),
    .fall_seen_q (a_fall_seen),
    .rise_cnt_q  (a_rise_cnt),
    .fall_cnt_q  (a_fall_cnt),
    .active_q    (a_active)
  );

  dpcc_unit u_unit_b (
    .sys_clk     (sys_clk),
    .reset_n     (reset_n),
    .enable      (ctrl_q[`DPCC_BIT_EN + `DPCC_B_OFS]),
    .repeat_mode (ctrl_q[`DPCC_BIT_REP + `DPCC_B_OFS]),
    .rise_en     (ctrl_q[`DPCC_BIT_RISE + `DPCC_B_OFS]),
    .fall_en     (ctrl_q[`DPCC_BIT_FALL + `DPCC_B_OFS]),
    .trig        (trig_b),
    .q0          (quantity0),
    .q1          (quantity1),
    .q2          (quantity2),
    .cap0_q      (b_cap0),
    .cap1_q      (b_cap1),
    .cap2_q      (b_cap2),
    .rise_seen_q (b_rise_seen),
    .fall_seen_q (b_fall_seen),
    .rise_cnt_q  (b_rise_cnt),
    .fall_cnt_q  (b_fall_cnt),
    .active_q    (b_active)
  );

  // ************************************************************
  // Write decode and selector lock
  // ************************************************************
  assign wr16   = obj_wdata[15:0];
  assign sel_w  = obj_wr && hit(`DPCC_IDX_SELECT, `DPCC_SUB_COUNT);
  assign ctrl_w = obj_wr && hit(`DPCC_IDX_CTRL, `DPCC_SUB_COUNT);
  assign srca_w = obj_wr && hit(`DPCC_IDX_SRC, `DPCC_SUB_V0);
  assign srcb_w = obj_wr && hit(`DPCC_IDX_SRC, `DPCC_SUB_V1);

  assign sel_locked = (select_q == `DPCC_SEL_CUSTOM)
                    ? (unit_a_active_flag | unit_b_active_flag)
                    : ((ctrl_q[`DPCC_BIT_EN] & stat_q[`DPCC_BIT_EN])
                       | (ctrl_q[`DPCC_BIT_EN + `DPCC_B_OFS]
                          & stat_q[`DPCC_BIT_EN + `DPCC_B_OFS]));

  always @* begin
    wr_ok_d = 1'b0;
    if (ctrl_w || srca_w || srcb_w) begin
      wr_ok_d = 1'b1;
    end else if (sel_w) begin
      wr_ok_d = ((wr16 == `DPCC_SEL_CUSTOM) || (wr16 == `DPCC_SEL_CIA402))
              && (!sel_locked || (wr16 == select_q));
    end
  end

  always @(posedge sys_clk) begin
    if (!reset_n) begin
      ctrl_q   <= `DPCC_CTRL_RST;
      select_q <= `DPCC_SEL_CUSTOM;
      src_a_q  <= `DPCC_SRC_A_RST;
      src_b_q  <= `DPCC_SRC_B_RST;
    end else begin
      if (ctrl_w) begin
        ctrl_q <= wr16 & `DPCC_CTRL_MASK;
      end
      if (sel_w && wr_ok_d) begin
        select_q <= wr16;
      end
      if (srca_w) begin
        src_a_q <= wr16;
      end
      if (srcb_w) begin
        src_b_q <= wr16;
      end
    end
  end

  // ************************************************************
  // Status word and active flags
  // ************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      stat_q             <= 16'h0000;
      unit_a_active_flag <= 1'b0;
      unit_b_active_flag <= 1'b0;
    end else begin
      stat_q <= 16'h0000;
      stat_q[`DPCC_BIT_EN]        <= ctrl_q[`DPCC_BIT_EN];
      stat_q[`DPCC_ST_RISE]       <= a_rise_seen;
      stat_q[`DPCC_ST_FALL]       <= a_fall_seen;
      stat_q[`DPCC_BIT_USER0]     <= ctrl_q[`DPCC_BIT_USER0];
      stat_q[`DPCC_BIT_USER1]     <= ctrl_q[`DPCC_BIT_USER1];
      stat_q[`DPCC_BIT_EN + BE]   <= ctrl_q[`DPCC_BIT_EN + BE];
      stat_q[`DPCC_ST_RISE + BE]  <= b_rise_seen;
      stat_q[`DPCC_ST_FALL + BE]  <= b_fall_seen;
      stat_q[`DPCC_BIT_USER0 + BE] <= ctrl_q[`DPCC_BIT_USER0 + BE];
      stat_q[`DPCC_BIT_USER1 + BE] <= ctrl_q[`DPCC_BIT_USER1 + BE];
      unit_a_active_flag <= a_active;
      unit_b_active_flag <= b_active;
    end
  end

  // ************************************************************
  // Read decode
  // ************************************************************
  always @* begin
    rd_d     = 32'h00000000;
    rd_hit_d = 1'b1;
    case (obj_index)
      `DPCC_IDX_VAL32_B: begin
        case (obj_sub)
          `DPCC_SUB_COUNT: rd_d = `DPCC_GROUP_COUNT;
          `DPCC_SUB_V0:    rd_d = b_cap0;
          `DPCC_SUB_V1:    rd_d = b_cap1;
          `DPCC_SUB_V2:    rd_d = b_cap2;
          default:         rd_hit_d = 1'b0;
        endcase
      end
      `DPCC_IDX_HALF_B: begin
        case (obj_sub)
          `DPCC_SUB_COUNT: rd_d = `DPCC_GROUP_COUNT;
          `DPCC_SUB_V0: rd_d = {{16{b_cap0[15]}}, b_cap0[15:0]};
          `DPCC_SUB_V1: rd_d = {{16{b_cap1[15]}}, b_cap1[15:0]};
          `DPCC_SUB_V2: rd_d = {{16{b_cap2[15]}}, b_cap2[15:0]};
          default:         rd_hit_d = 1'b0;
        endcase
      end
      `DPCC_IDX_OCTET_B: begin
        case (obj_sub)
          `DPCC_SUB_COUNT: rd_d = `DPCC_GROUP_COUNT;
          `DPCC_SUB_V0:    rd_d = {{24{b_cap0[7]}}, b_cap0[7:0]};
          `DPCC_SUB_V1:    rd_d = {{24{b_cap1[7]}}, b_cap1[7:0]};
          `DPCC_SUB_V2:    rd_d = {{24{b_cap2[7]}}, b_cap2[7:0]};
          default:         rd_hit_d = 1'b0;
        endcase
      end
      `DPCC_IDX_SRC: begin
        case (obj_sub)
          `DPCC_SUB_COUNT: rd_d = `DPCC_SRC_COUNT;
          `DPCC_SUB_V0:    rd_d = {{16{src_a_q[15]}}, src_a_q};
          `DPCC_SUB_V1:    rd_d = {{16{src_b_q[15]}}, src_b_q};
          default:         rd_hit_d = 1'b0;
        endcase
      end
      `DPCC_IDX_SELECT: rd_d = {16'h0000, select_q};
      `DPCC_IDX_CTRL:   rd_d = {16'h0000, ctrl_q};
      `DPCC_IDX_STAT:   rd_d = {16'h0000, stat_q};
      `DPCC_IDX_RCNT_A: rd_d = {16'h0000, a_rise_cnt};
      `DPCC_IDX_FCNT_A: rd_d = {16'h0000, a_fall_cnt};
      `DPCC_IDX_RCNT_B: rd_d = {16'h0000, b_rise_cnt};
      `DPCC_IDX_FCNT_B: rd_d = {16'h0000, b_fall_cnt};
      default:          rd_hit_d = 1'b0;
    endcase
    if ((obj_sub != `DPCC_SUB_COUNT)
        && ((obj_index == `DPCC_IDX_SELECT) || (obj_index == `DPCC_IDX_CTRL)
            || (obj_index == `DPCC_IDX_STAT)
            || (obj_index[15:4] == 12'h60D
                && obj_index != `DPCC_IDX_SRC))) begin
      rd_hit_d = 1'b0;
      rd_d     = 32'h00000000;
    end
  end

  // ************************************************************
  // Access answer
  // ************************************************************
  always @(posedge sys_clk) begin
    if (!reset_n) begin
      obj_rdata <= 32'h00000000;
      obj_ack   <= 1'b0;
      obj_err   <= 1'b0;
    end else begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      if (obj_wr) begin
        obj_ack <= wr_ok_d;
        obj_err <= ~wr_ok_d;
      end else if (obj_rd) begin
        obj_rdata <= rd_d;
        obj_ack   <= rd_hit_d;
        obj_err   <= ~rd_hit_d;
      end
    end
  end
endmodule // dpcc_top

/* File: dpcc_checker.sv */
`timescale 1ns/10ps
`include "dpcc_consts.vh"
module dpcc_checker (
  input wire logic        sys_clk,            // System clock
  input wire logic        reset_n,            // Reset, active low
  input wire logic [15:0] obj_index,          // Object index
  input wire logic [7:0]  obj_sub,            // Object subindex
  input wire logic        obj_wr,             // Write strobe
  input wire logic        obj_rd,             // Read strobe
  input wire logic [31:0] obj_wdata,          // Write data
  input wire logic [31:0] obj_rdata,          // Read data
  input wire logic        obj_ack,            // Accept pulse
  input wire logic        obj_err,            // Refuse pulse
  input wire logic        unit_a_active_flag, // Unit A armed
  input wire logic        unit_b_active_flag  // Unit B armed
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // ************************************************************
  // Access answers
  // ************************************************************
  AST_ANSWER: assert property (
    (obj_wr || obj_rd) |=> (obj_ack ^ obj_err))
    else $error("access got no single answer");
  AST_NO_SPUR: assert property (
    !(obj_wr || obj_rd) |=> !obj_ack && !obj_err)
    else $error("answer without access");
  AST_RDATA_HOLD: assert property (
    !obj_rd |=> $stable(obj_rdata))
    else $error("read data moved without read");
  AST_SEL_RANGE: assert property (
    obj_wr && obj_index == `DPCC_IDX_SELECT
    && obj_wdata[15:0] > 16'h0001 |=> obj_err)
    else $error("selector value out of range accepted");

  // ************************************************************
  // Read-only objects and units idle after reset
  // ************************************************************
  AST_STAT_RO: assert property (
    obj_wr && obj_index == `DPCC_IDX_STAT |=> obj_err)
    else $error("status write accepted");
  AST_HALF_RO: assert property (
    obj_wr && obj_index == `DPCC_IDX_HALF_B |=> obj_err)
    else $error("halfword copy write accepted");
  AST_OCTET_RO: assert property (
    obj_wr && obj_index == `DPCC_IDX_OCTET_B |=> obj_err)
    else $error("octet copy write accepted");
  AST_VAL32_RO: assert property (
    obj_wr && obj_index == `DPCC_IDX_VAL32_B |=> obj_err)
    else $error("captured value write accepted");
  AST_CNT_RO: assert property (
    obj_wr && obj_index == `DPCC_IDX_RCNT_A |=> obj_err)
    else $error("counter write accepted");
  AST_IDLE_RST: assert property (
    $rose(reset_n) |-> !unit_a_active_flag && !unit_b_active_flag
    ##1 !unit_a_active_flag && !unit_b_active_flag)
    else $error("unit armed after reset");
endmodule // dpcc_checker

bind dpcc_top dpcc_checker dpcc_checker_inst (
  .sys_clk(sys_clk), .reset_n(reset_n), .obj_index(obj_index),
  .obj_sub(obj_sub), .obj_wr(obj_wr), .obj_rd(obj_rd),
  .obj_wdata(obj_wdata), .obj_rdata(obj_rdata), .obj_ack(obj_ack),
  .obj_err(obj_err), .unit_a_active_flag(unit_a_active_flag),
  .unit_b_active_flag(unit_b_active_flag)
);

/* File: dpcc_probe_model.sv */
`timescale 1ns/10ps
// ************************************************************
// Probe pins and index pulses; each request toggles one pin
// ************************************************************
module dpcc_probe_model (
  input  wire logic       sys_clk,  // System clock
  input  wire logic       reset_n,  // Reset, active low
  input  wire logic [3:0] edge_req, // Toggle request per pin
  output logic      [3:0] pins_q    // probe1, probe2, fb index, master
);
  always @(posedge sys_clk) begin
    if (!reset_n)
      pins_q <= 4'h0;
    else
      pins_q <= pins_q ^ edge_req;
  end
endmodule // dpcc_probe_model

/* File: tb_dpcc_top.sv */
`timescale 1ns/10ps
`include "dpcc_consts.vh"
module tb_dpcc_top;
  reg         sys_clk;
  reg         reset_n;
  reg  [3:0]  edge_req;
  wire [3:0]  pins;
  reg  [31:0] q0, q1, q2, wdata, rd_val;
  reg  [15:0] idx;
  reg  [7:0]  sub;
  reg         wr, rd, acc_ok;
  wire [31:0] rdata;
  wire        ack, err, a_act, b_act;
  integer     n_fail, comparisons;

  dpcc_probe_model dpcc_probe_model_inst (.sys_clk(sys_clk),
    .reset_n(reset_n), .edge_req(edge_req), .pins_q(pins));
  dpcc_top dpcc_top_inst (.sys_clk(sys_clk), .reset_n(reset_n),
    .probe_in1(pins[0]), .probe_in2(pins[1]), .fb_index(pins[2]),
    .master_index(pins[3]), .quantity0(q0), .quantity1(q1),
    .quantity2(q2), .obj_index(idx), .obj_sub(sub), .obj_wr(wr),
    .obj_rd(rd), .obj_wdata(wdata), .obj_rdata(rdata), .obj_ack(ack),
    .obj_err(err), .unit_a_active_flag(a_act), .unit_b_active_flag(b_act));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  task chk(input [31:0] got, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask

  task finish_test;
    begin
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask

  // One strobe cycle, then wait for the answer pulse
  task access(input w, input [15:0] i, input [7:0] s, input [31:0] d);
    integer n;
    begin
      idx = i;
      sub = s;
      wdata = d;
      wr = w;
      rd = !w;
      @(negedge sys_clk);
      wr = 1'b0;
      rd = 1'b0;
      n = 0;
      while (ack !== 1'b1 && err !== 1'b1 && n < 20) begin
        @(negedge sys_clk);
        n = n + 1;
      end
      if (n == 20) begin
        n_fail = n_fail + 1;
        $display("BAD %0t no answer", $time);
        finish_test;
      end else begin
        acc_ok = ack;
        rd_val = rdata;
        // Idle cycle so that the next strobe is a fresh rise
        @(negedge sys_clk);
      end
    end
  endtask

  task wr_t(input [15:0] i, input [7:0] s, input [31:0] d, input ok);
    begin
      access(1'b1, i, s, d);
      chk({31'h0, acc_ok}, {31'h0, ok});
    end
  endtask

  task rd_t(input [15:0] i, input [7:0] s, input [31:0] exp);
    begin
      access(1'b0, i, s, 32'h0);
      chk({31'h0, acc_ok}, 32'h1);
      chk(rd_val, exp);
    end
  endtask

  task pin(input integer p);
    begin
      edge_req[p] = 1'b1;
      @(negedge sys_clk);
      edge_req = 4'h0;
      repeat (8) @(negedge sys_clk);
    end
  endtask

  initial begin
    n_fail = 0;
    comparisons = 0;
    reset_n = 1'b0;
    edge_req = 4'h0;
    {q0, q1, q2, wdata} = {4{32'h0}};
    idx = 16'h0;
    sub = 8'h0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    // ************************************************************
    // Reset values and refusals
    // ************************************************************
    rd_t(`DPCC_IDX_CTRL, 8'h00, 32'h0);
    rd_t(`DPCC_IDX_SELECT, 8'h00, 32'h0);
    rd_t(`DPCC_IDX_HALF_B, 8'h00, 32'h3);
    rd_t(`DPCC_IDX_OCTET_B, 8'h00, 32'h3);
    rd_t(`DPCC_IDX_SRC, 8'h01, 32'h1);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'h0);
    wr_t(`DPCC_IDX_STAT, 8'h00, 32'h1, 1'b0);
    wr_t(`DPCC_IDX_HALF_B, 8'h01, 32'h1, 1'b0);
    wr_t(`DPCC_IDX_OCTET_B, 8'h01, 32'h1, 1'b0);
    wr_t(`DPCC_IDX_VAL32_B, 8'h01, 32'h1, 1'b0);
    wr_t(`DPCC_IDX_RCNT_A, 8'h00, 32'h1, 1'b0);
    access(1'b0, 16'h1234, 8'h00, 32'h0);
    chk({31'h0, acc_ok}, 32'h0);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h2, 1'b0);
    // ************************************************************
    // Control masking and interface lock
    // ************************************************************
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'hFFFF, 1'b1);
    rd_t(`DPCC_IDX_CTRL, 8'h00, 32'hF7F7);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'hC1C1);
    chk({30'h0, a_act, b_act}, 32'h3);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h1, 1'b0);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h0, 1'b1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0, 1'b1);
    // Active flags trail the control word by two clocks
    repeat (2) @(negedge sys_clk);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h1, 1'b1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0100, 1'b1);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h0, 1'b0);
    rd_t(`DPCC_IDX_SELECT, 8'h00, 32'h1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0, 1'b1);
    wr_t(`DPCC_IDX_SELECT, 8'h00, 32'h0, 1'b1);
    // ************************************************************
    // Unit B single capture on probe input 2
    // ************************************************************
    wr_t(`DPCC_IDX_SRC, 8'h02, 32'h2, 1'b1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h3100, 1'b1);
    q0 = 32'h12348765;
    q1 = 32'hFFFF80FE;
    q2 = 32'h0000007F;
    pin(1);
    rd_t(`DPCC_IDX_VAL32_B, 8'h01, 32'h12348765);
    rd_t(`DPCC_IDX_HALF_B, 8'h01, 32'hFFFF8765);
    rd_t(`DPCC_IDX_HALF_B, 8'h02, 32'hFFFF80FE);
    rd_t(`DPCC_IDX_OCTET_B, 8'h01, 32'h65);
    rd_t(`DPCC_IDX_OCTET_B, 8'h02, 32'hFFFFFFFE);
    rd_t(`DPCC_IDX_OCTET_B, 8'h03, 32'h7F);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'h0300);
    rd_t(`DPCC_IDX_RCNT_B, 8'h00, 32'h1);
    q0 = 32'h00C0FFEE;
    pin(1);
    rd_t(`DPCC_IDX_HALF_B, 8'h01, 32'hFFFFFFEE);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'h0700);
    rd_t(`DPCC_IDX_FCNT_B, 8'h00, 32'h1);
    chk({31'h0, b_act}, 32'h0);
    pin(1);
    rd_t(`DPCC_IDX_RCNT_B, 8'h00, 32'h1);
    // ************************************************************
    // Unit B repetitive, unit A on encoder index
    // ************************************************************
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0, 1'b1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h3300, 1'b1);
    pin(1);
    pin(1);
    rd_t(`DPCC_IDX_FCNT_B, 8'h00, 32'h2);
    rd_t(`DPCC_IDX_RCNT_B, 8'h00, 32'h2);
    chk({31'h0, b_act}, 32'h1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0015, 1'b1);
    pin(2);
    pin(2);
    rd_t(`DPCC_IDX_RCNT_A, 8'h00, 32'h1);
    rd_t(`DPCC_IDX_FCNT_A, 8'h00, 32'h0);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'h0003);
    chk({31'h0, a_act}, 32'h0);
    // ************************************************************
    // Unit A on the master encoder index
    // ************************************************************
    wr_t(`DPCC_IDX_SRC, 8'h01, 32'hFFFF, 1'b1);
    rd_t(`DPCC_IDX_SRC, 8'h01, 32'hFFFFFFFF);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0, 1'b1);
    wr_t(`DPCC_IDX_CTRL, 8'h00, 32'h0011, 1'b1);
    pin(3);
    rd_t(`DPCC_IDX_RCNT_A, 8'h00, 32'h2);
    rd_t(`DPCC_IDX_STAT, 8'h00, 32'h0003);
    finish_test;
  end
endmodule // tb_dpcc_top
